// file: hdl/rrs_exec.sv
`timescale 1ns/10ps
// execution slice for return, right rotate, subtract-with-borrow, page write
module rrs_exec
   import rrs_pkg::*;
(
   input  wire logic                 ref_clk_in,
   input  wire logic                 rst_n_in,
   input  wire logic                 issue_in,
   input  wire rrs_req_t             req_in,
   input  wire logic [RRS_PC_W-1:0]  stack_top_in,
   input  wire logic                 stack_push_in,
   output logic                      ready_out,
   output logic                      done_out,
   output logic      [RRS_PC_W-1:0]  pc_out,
   output logic      [RRS_LVL_W-1:0] stack_level_out,
   output logic      [7:0]           work_out,
   output rrs_flags_t                flags_out,
   output rrs_dwr_t                  dwr_out,
   output rrs_swr_t                  swr_out
);

   rrs_state_t           state_ff,  nxt_state;
   logic [RRS_PC_W-1:0]  pc_ff,     nxt_pc;
   logic [RRS_LVL_W-1:0] lvl_ff,    nxt_lvl;
   logic [7:0]           work_ff,   nxt_work;
   rrs_flags_t           flags_ff,  nxt_flags;
   rrs_dwr_t             dwr_ff,    nxt_dwr;
   rrs_swr_t             swr_ff,    nxt_swr;
   logic                 done_ff,   nxt_done;

   logic [7:0]           alu_opnd;
   logic [7:0]           sbc_res;
   rrs_flags_t           sbc_flags;
   logic [7:0]           rot_res;
   logic                 rot_carry;
   logic                 take;

   // a request is only taken while no return is in its second cycle
   assign ready_out = (state_ff == ST_IDLE);
   assign take      = issue_in && ready_out;

   // immediate form feeds the adder with the literal instead of the register
   assign alu_opnd = (req_in.op == OP_SUB_BORROW_FROM_IMMEDIATE) ? req_in.imm : req_in.rdata;

   rrs_alu u_alu (
      .opnd_in       (alu_opnd),
      .work_in       (work_ff),
      .carry_in      (flags_ff.carry),
      .sbc_res_out   (sbc_res),
      .sbc_flags_out (sbc_flags),
      .rot_res_out   (rot_res),
      .rot_carry_out (rot_carry)
   );

   // next-state logic: strobes last one cycle, everything else holds by default
   always_comb begin
      nxt_state = state_ff;
      nxt_pc    = pc_ff;
      nxt_lvl   = lvl_ff;
      nxt_work  = work_ff;
      nxt_flags = flags_ff;
      nxt_dwr   = '0;
      nxt_swr   = '0;
      nxt_done  = 1'b0;
      case (state_ff)
         ST_IDLE: begin
            if (take) begin
               case (req_in.op)
                  OP_SUBROUTINE_RETURN: begin
                     nxt_state = ST_POP_LOAD;
                  end
                  OP_ROTATE_RIGHT_THRU_CARRY: begin
                     nxt_flags.carry = rot_carry;
                     nxt_done        = 1'b1;
                     if (req_in.dir == RRS_DIR_TO_WORK) begin
                        nxt_work = rot_res;
                     end else begin
                        nxt_dwr = '{we: 1'b1, addr: req_in.raddr, data: rot_res};
                     end
                  end
                  OP_SUB_BORROW_FROM_REGISTER: begin
                     nxt_flags = sbc_flags;
                     nxt_done  = 1'b1;
                     if (req_in.dir == RRS_DIR_TO_WORK) begin
                        nxt_work = sbc_res;
                     end else begin
                        nxt_dwr = '{we: 1'b1, addr: req_in.raddr, data: sbc_res};
                     end
                  end
                  OP_SUB_BORROW_FROM_IMMEDIATE: begin
                     nxt_flags = sbc_flags;
                     nxt_work  = sbc_res;
                     nxt_done  = 1'b1;
                  end
                  OP_SECONDARY_PAGE_WRITE: begin
                     // out-of-range index completes but writes nothing
                     nxt_done = 1'b1;
                     if (req_in.sidx <= RRS_SPAGE_IDX_MAX) begin
                        nxt_swr = '{we: 1'b1, idx: req_in.sidx, data: work_ff};
                     end
                  end
                  default: begin
                     nxt_done = 1'b0;
                  end
               endcase
            end
         end
         ST_POP_LOAD: begin
            // second cycle: stack top is sampled here, flags never touched
            nxt_pc    = stack_top_in;
            nxt_lvl   = lvl_ff - RRS_LVL_ONE;
            nxt_done  = 1'b1;
            nxt_state = ST_IDLE;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
      // a call pushing in the same cycle as the pop cancels it out
      if (stack_push_in) begin
         nxt_lvl = nxt_lvl + RRS_LVL_ONE;
      end
   end

   // state registers only
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_ff <= ST_IDLE;
         pc_ff    <= RRS_PC_RST;
         lvl_ff   <= RRS_LVL_RST;
         work_ff  <= RRS_WORK_RST;
         flags_ff <= RRS_FLAGS_RST;
         dwr_ff   <= '0;
         swr_ff   <= '0;
         done_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         pc_ff    <= nxt_pc;
         lvl_ff   <= nxt_lvl;
         work_ff  <= nxt_work;
         flags_ff <= nxt_flags;
         dwr_ff   <= nxt_dwr;
         swr_ff   <= nxt_swr;
         done_ff  <= nxt_done;
      end
   end

   assign done_out        = done_ff;
   assign pc_out          = pc_ff;
   assign stack_level_out = lvl_ff;
   assign work_out        = work_ff;
   assign flags_out       = flags_ff;
   assign dwr_out         = dwr_ff;
   assign swr_out         = swr_ff;

   // helper: expected 9-bit borrow sums from the operands of the taken request
   logic [8:0] exp_reg9;
   logic [8:0] exp_imm9;
   assign exp_reg9 = {1'b0, req_in.rdata} + {1'b0, ~work_ff} + {8'h00, flags_ff.carry};
   assign exp_imm9 = {1'b0, req_in.imm} + {1'b0, ~work_ff} + {8'h00, flags_ff.carry};

   // checks on the observable behaviour
   AST_RTN_PC: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      take && req_in.op == OP_SUBROUTINE_RETURN |=> !ready_out && !done_out
      ##1 done_out && ready_out && pc_out == $past(stack_top_in))
      else $error("return did not load pc on its second cycle");

   AST_RTN_LEVEL: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      take && req_in.op == OP_SUBROUTINE_RETURN && !stack_push_in ##1 !stack_push_in
      |=> stack_level_out == $past(stack_level_out, 2) - RRS_LVL_ONE)
      else $error("return did not lower stack level by one");

   AST_RTN_FLAGS: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      take && req_in.op == OP_SUBROUTINE_RETURN |=> $stable(flags_out) ##1 $stable(flags_out))
      else $error("return changed a flag");

   AST_ROT_RESULT: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      take && req_in.op == OP_ROTATE_RIGHT_THRU_CARRY && req_in.dir == RRS_DIR_TO_WORK
      |=> work_out == {$past(flags_out.carry), $past(req_in.rdata[7:1])}
          && flags_out.carry == $past(req_in.rdata[0]) && done_out)
      else $error("rotate right result or carry wrong");

   AST_ROT_FLAGS: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      take && req_in.op == OP_ROTATE_RIGHT_THRU_CARRY
      |=> $stable(flags_out.zero) && $stable(flags_out.half_carry_flag) && ready_out)
      else $error("rotate right touched zero or half carry");

   AST_DIR_REG: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      take && req_in.dir == RRS_DIR_TO_REG
      && (req_in.op == OP_ROTATE_RIGHT_THRU_CARRY || req_in.op == OP_SUB_BORROW_FROM_REGISTER)
      |=> dwr_out.we && dwr_out.addr == $past(req_in.raddr) && $stable(work_out)
      // back-to-back write-backs are legal, so the next strobe must follow the next request
      ##1 (dwr_out.we == $past(take && req_in.dir == RRS_DIR_TO_REG
          && (req_in.op == OP_ROTATE_RIGHT_THRU_CARRY
              || req_in.op == OP_SUB_BORROW_FROM_REGISTER))))
      else $error("direction one did not write back to the data register");

   AST_DIR_WORK: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      take && req_in.dir == RRS_DIR_TO_WORK && req_in.op == OP_SUB_BORROW_FROM_REGISTER
      |=> !dwr_out.we && work_out == $past(exp_reg9[7:0]))
      else $error("direction zero did not land in the working register");

   AST_SBC_REG: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      take && req_in.op == OP_SUB_BORROW_FROM_REGISTER && req_in.dir == RRS_DIR_TO_REG
      |=> dwr_out.data == $past(exp_reg9[7:0]) && flags_out.carry == $past(exp_reg9[8]))
      else $error("register subtract-with-borrow value or carry wrong");

   AST_SBC_IMM: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      take && req_in.op == OP_SUB_BORROW_FROM_IMMEDIATE
      |=> {flags_out.carry, work_out} == $past(exp_imm9) && !dwr_out.we && done_out)
      else $error("immediate subtract-with-borrow wrong");

   AST_SBC_ZERO: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      take && req_in.op == OP_SUB_BORROW_FROM_IMMEDIATE
      |=> flags_out.zero == (work_out == RRS_BYTE_ZERO)
          && flags_out.half_carry_flag == ($past({1'b0, req_in.imm[3:0]})
             + {1'b0, ~$past(work_ff[3:0])} + {4'h0, $past(flags_ff.carry)}) >> 4)
      else $error("zero or half carry wrong after subtract-with-borrow");

   AST_SPAGE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      take && req_in.op == OP_SECONDARY_PAGE_WRITE && req_in.sidx <= RRS_SPAGE_IDX_MAX
      |=> swr_out.we && swr_out.data == $past(work_out) && swr_out.idx == $past(req_in.sidx)
          && $stable(flags_out) && ready_out)
      else $error("secondary page write wrong");

   COV_RTN:   cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      take && req_in.op == OP_SUBROUTINE_RETURN ##2 done_out);
   COV_ROT:   cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      take && req_in.op == OP_ROTATE_RIGHT_THRU_CARRY && req_in.dir == RRS_DIR_TO_REG);
   COV_ZERO:  cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      take && req_in.op == OP_SUB_BORROW_FROM_REGISTER ##1 flags_out.zero);
   COV_SPAGE: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      take && req_in.op == OP_SECONDARY_PAGE_WRITE ##1 swr_out.we);

endmodule : rrs_exec

// file: hdl/rrs_pkg.sv
// Behaviour
// - The subroutine return loads the program counter from the top return-stack entry, lowers the stack level by one, keeps every flag, and takes 2 instruction cycles.
// - The right rotate moves the register operand one place toward bit 0, with the old carry entering bit 7 and operand bit 0 becoming the new carry.
// - For the rotate and the register subtract-with-borrow, direction 0 sends the result to the working register and direction 1 writes it back to data register 0 to 127.
// - The right rotate finishes in one cycle and changes only the carry flag, leaving zero and half carry as they were.
// - The register subtract-with-borrow adds register, inverted working register and carry, stores per direction, and updates zero, half carry and carry in one cycle.
// - The immediate subtract-with-borrow adds the 8-bit immediate, inverted working register and carry, always into the working register, updating all three flags in one cycle.
// - The secondary page write copies the working register into secondary control page entry 0 to 21 in one cycle and changes no flag.
package rrs_pkg;

   // instruction selector seen at the request port
   typedef enum logic [2:0] {
      OP_NONE,
      OP_SUBROUTINE_RETURN,
      OP_ROTATE_RIGHT_THRU_CARRY,
      OP_SUB_BORROW_FROM_REGISTER,
      OP_SUB_BORROW_FROM_IMMEDIATE,
      OP_SECONDARY_PAGE_WRITE
   } rrs_op_t;

   // execution sequencer states
   typedef enum logic {
      ST_IDLE,
      ST_POP_LOAD
   } rrs_state_t;

   localparam int          RRS_PC_W          = 11;
   localparam int          RRS_LVL_W         = 3;
   localparam logic        RRS_DIR_TO_WORK   = 1'b0;
   localparam logic        RRS_DIR_TO_REG    = 1'b1;
   localparam logic [6:0]  RRS_REG_ADDR_MAX  = 7'h7F;
   localparam logic [4:0]  RRS_SPAGE_IDX_MAX = 5'h15;
   localparam logic [7:0]  RRS_WORK_RST      = 8'h00;
   localparam logic [10:0] RRS_PC_RST        = 11'h000;
   localparam logic [2:0]  RRS_LVL_RST       = 3'h0;
   localparam logic [2:0]  RRS_LVL_ONE       = 3'h1;
   localparam logic [2:0]  RRS_FLAGS_RST     = 3'h0;
   localparam logic [7:0]  RRS_BYTE_ZERO     = 8'h00;

   // one instruction with all its operands
   typedef struct packed {
      rrs_op_t    op;
      logic       dir;
      logic [6:0] raddr;
      logic [7:0] rdata;
      logic [7:0] imm;
      logic [4:0] sidx;
   } rrs_req_t;

   // status bits touched by this slice
   typedef struct packed {
      logic zero;
      logic half_carry_flag;
      logic carry;
   } rrs_flags_t;

   // data register write-back strobe
   typedef struct packed {
      logic       we;
      logic [6:0] addr;
      logic [7:0] data;
   } rrs_dwr_t;

   // secondary control page write strobe
   typedef struct packed {
      logic       we;
      logic [4:0] idx;
      logic [7:0] data;
   } rrs_swr_t;

endpackage : rrs_pkg

// file: hdl/rrs_alu.sv
`timescale 1ns/10ps
// pure combinational datapath: subtract-with-borrow adder and right rotate
module rrs_alu
   import rrs_pkg::*;
(
   input  wire logic [7:0] opnd_in,
   input  wire logic [7:0] work_in,
   input  wire logic       carry_in,
   output logic      [7:0] sbc_res_out,
   output rrs_flags_t      sbc_flags_out,
   output logic      [7:0] rot_res_out,
   output logic            rot_carry_out
);

   logic [8:0] sum9;
   logic [4:0] sum5;

   // operand plus inverted working register plus carry, widened for carry out
   always_comb begin
      sum9 = {1'b0, opnd_in} + {1'b0, ~work_in} + {8'h00, carry_in};
      sum5 = {1'b0, opnd_in[3:0]} + {1'b0, ~work_in[3:0]} + {4'h0, carry_in};
   end

   // carry set means no borrow happened
   assign sbc_res_out                   = sum9[7:0];
   assign sbc_flags_out.carry           = sum9[8];
   assign sbc_flags_out.half_carry_flag = sum5[4];
   assign sbc_flags_out.zero            = (sum9[7:0] == RRS_BYTE_ZERO);

   // old carry enters at the top, bit 0 leaves as new carry
   assign rot_res_out   = {carry_in, opnd_in[7:1]};
   assign rot_carry_out = opnd_in[0];

endmodule : rrs_alu

// file: test/test_return_rotate_subtract_exec.sv
`timescale 1ns/10ps
// self-checking bench: directed corner cases, then a seeded random instruction stream
module test_return_rotate_subtract_exec
   import rrs_pkg::*;
();
   // one expected completion, noted by the driver and consumed by the monitor
   typedef struct packed {
      logic [31:0]          cyc;
      logic [7:0]           work;
      rrs_flags_t           flags;
      logic [RRS_PC_W-1:0]  pc;
      logic [RRS_LVL_W-1:0] lvl;
      rrs_dwr_t             dwr;
      rrs_swr_t             swr;
   } rrs_tb_exp_t;

   localparam int LIMIT = 3000;  // a few times the expected run length

   logic                 ref_clk_in;
   logic                 rst_n_in;
   logic                 issue_in;
   rrs_req_t             req_in;
   logic [RRS_PC_W-1:0]  stack_top_in;
   logic                 stack_push_in;
   logic                 ready_out;
   logic                 done_out;
   logic [RRS_PC_W-1:0]  pc_out;
   logic [RRS_LVL_W-1:0] stack_level_out;
   logic [7:0]           work_out;
   rrs_flags_t           flags_out;
   rrs_dwr_t             dwr_out;
   rrs_swr_t             swr_out;
   rrs_tb_exp_t          exp_q[$];
   rrs_tb_exp_t          got;
   int                   mismatches   = 0;
   int                   total_checks = 0;
   int                   cyc          = 0;
   // reference state, starting from the reset values
   logic [7:0]           m_work = RRS_WORK_RST;
   logic                 m_c    = 1'b0;
   logic                 m_z    = 1'b0;
   logic                 m_half = 1'b0;
   logic [RRS_PC_W-1:0]  m_pc   = RRS_PC_RST;
   logic [RRS_LVL_W-1:0] m_lvl  = RRS_LVL_RST;

   rrs_exec u_dut (
      .ref_clk_in      (ref_clk_in),
      .rst_n_in        (rst_n_in),
      .issue_in        (issue_in),
      .req_in          (req_in),
      .stack_top_in    (stack_top_in),
      .stack_push_in   (stack_push_in),
      .ready_out       (ready_out),
      .done_out        (done_out),
      .pc_out          (pc_out),
      .stack_level_out (stack_level_out),
      .work_out        (work_out),
      .flags_out       (flags_out),
      .dwr_out         (dwr_out),
      .swr_out         (swr_out)
   );

   // 20 MHz clock
   initial begin
      ref_clk_in = 1'b0;
      forever #25 ref_clk_in = ~ref_clk_in;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] expd, input string what);
      total_checks++;
      if (seen !== expd) begin
         mismatches++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, expd);
      end
   endtask : check

   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : complete_run

   // issue one instruction at a rising edge and note what its completion must show
   task automatic run_op(input rrs_op_t op, input logic dir, input logic [6:0] ra,
                         input logic [7:0] d, input logic [4:0] si, input logic psh);
      rrs_req_t            r;
      rrs_tb_exp_t         e;
      logic [8:0]          s;
      logic [4:0]          h;
      logic [7:0]          a;
      logic [7:0]          res;
      logic [RRS_PC_W-1:0] top;
      r   = '{op: op, dir: dir, raddr: ra, rdata: d, imm: {d[3:0], d[7:4]}, sidx: si};
      top = RRS_PC_W'($urandom);
      e   = '0;
      psh = psh && (op != OP_SUBROUTINE_RETURN);
      @(posedge ref_clk_in);
      issue_in      <= 1'b1;
      req_in        <= r;
      stack_push_in <= psh;
      stack_top_in  <= top;
      m_lvl = m_lvl + RRS_LVL_W'(psh);
      e.cyc = 32'(cyc + 2);
      res   = 8'h00;
      case (op)
         OP_ROTATE_RIGHT_THRU_CARRY: begin
            res = {m_c, d[7:1]};
            m_c = d[0];
         end
         OP_SUB_BORROW_FROM_REGISTER, OP_SUB_BORROW_FROM_IMMEDIATE: begin
            a    = (op == OP_SUB_BORROW_FROM_REGISTER) ? d : r.imm;
            s    = {1'b0, a} + {1'b0, ~m_work} + 9'(m_c);
            h    = {1'b0, a[3:0]} + {1'b0, ~m_work[3:0]} + 5'(m_c);
            res  = s[7:0];
            m_c  = s[8];
            m_half = h[4];
            m_z  = (res == RRS_BYTE_ZERO);
         end
         OP_SECONDARY_PAGE_WRITE: begin
            if (si <= RRS_SPAGE_IDX_MAX) e.swr = '{we: 1'b1, idx: si, data: m_work};
         end
         OP_SUBROUTINE_RETURN: begin
            m_pc  = top;
            m_lvl = m_lvl - RRS_LVL_ONE;
            e.cyc = 32'(cyc + 3);
         end
         default: ;
      endcase
      // destination select; the immediate form always lands in the working register
      if (op inside {OP_ROTATE_RIGHT_THRU_CARRY, OP_SUB_BORROW_FROM_REGISTER}
          && dir == RRS_DIR_TO_REG)
         e.dwr = '{we: 1'b1, addr: ra, data: res};
      else if (op inside {OP_ROTATE_RIGHT_THRU_CARRY, OP_SUB_BORROW_FROM_REGISTER,
                          OP_SUB_BORROW_FROM_IMMEDIATE})
         m_work = res;
      e.work  = m_work;
      e.flags = '{zero: m_z, half_carry_flag: m_half, carry: m_c};
      e.pc    = m_pc;
      e.lvl   = m_lvl;
      if (op != OP_NONE) exp_q.push_back(e);
      if (op == OP_SUBROUTINE_RETURN) begin
         // the return is taken at this edge; a request in the busy cycle must be ignored
         @(posedge ref_clk_in);
         r.op = OP_SECONDARY_PAGE_WRITE;
         req_in <= r;
         @(negedge ref_clk_in);
         check(16'(ready_out), 16'h0000, "ready in return cycle 2");
      end
   endtask : run_op

   // monitor: cycle count, timeout, and comparison of every completion with the oldest note
   always @(negedge ref_clk_in) begin
      cyc = cyc + 1;
      if (cyc == LIMIT) begin
         mismatches++;
         $display("MISMATCH at %0t: run did not finish in time", $time);
         complete_run();
      end else if (rst_n_in === 1'b1) begin
         if (done_out === 1'b1) begin
            if (exp_q.size() == 0) begin
               check(16'h0001, 16'h0000, "completion with nothing pending");
            end else begin
               got = exp_q.pop_front();
               check(16'(cyc), got.cyc[15:0], "completion cycle");
               check(16'(work_out), 16'(got.work), "working register");
               check(16'(flags_out), 16'(got.flags), "flags");
               check(16'(pc_out), 16'(got.pc), "program counter");
               check(16'(stack_level_out), 16'(got.lvl), "stack level");
               check(got.dwr.we ? 16'(dwr_out) : 16'(dwr_out.we), 16'(got.dwr), "data write");
               check(got.swr.we ? 16'(swr_out) : 16'(swr_out.we), 16'(got.swr), "page write");
            end
         end else begin
            check(16'({dwr_out.we, swr_out.we}), 16'h0000, "strobe without completion");
         end
      end
   end

   initial begin
      rst_n_in      = 1'b0;
      issue_in      = 1'b0;
      req_in        = '0;
      stack_top_in  = '0;
      stack_push_in = 1'b0;
      void'($urandom(32'hab0e));
      repeat (20) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      @(negedge ref_clk_in);
      check(16'({ready_out, flags_out, stack_level_out}), 16'h0040, "reset status");
      check(16'({work_out, 5'h00, pc_out[2:0]}), 16'h0000, "reset work and pc");
      // boundaries: top data address, last and first out-of-range page index, both directions
      run_op(OP_SUB_BORROW_FROM_IMMEDIATE, 1'b1, 7'h00, 8'h00, 5'h00, 1'b0);
      run_op(OP_ROTATE_RIGHT_THRU_CARRY, 1'b1, RRS_REG_ADDR_MAX, 8'hA5, 5'h00, 1'b1);
      run_op(OP_SUB_BORROW_FROM_REGISTER, 1'b1, 7'h00, 8'h06, 5'h00, 1'b0);
      run_op(OP_SECONDARY_PAGE_WRITE, 1'b0, 7'h00, 8'h00, RRS_SPAGE_IDX_MAX, 1'b0);
      run_op(OP_SECONDARY_PAGE_WRITE, 1'b0, 7'h00, 8'h00, 5'h16, 1'b0);
      run_op(OP_SUBROUTINE_RETURN, 1'b0, 7'h00, 8'h00, 5'h00, 1'b0);
      run_op(OP_NONE, 1'b0, 7'h00, 8'h00, 5'h00, 1'b0);
      run_op(OP_SUB_BORROW_FROM_REGISTER, 1'b0, 7'h11, 8'h06, 5'h00, 1'b0);
      // random stream, back to back, with occasional pushes and wrap of the level
      for (int i = 0; i < 400; i++) begin
         run_op(rrs_op_t'($urandom_range(5, 0)), 1'($urandom), 7'($urandom), 8'($urandom),
                5'($urandom_range(23, 0)), $urandom_range(7, 0) == 0);
      end
      @(posedge ref_clk_in);
      issue_in      <= 1'b0;
      stack_push_in <= 1'b0;
      repeat (4) @(posedge ref_clk_in);
      check(16'(exp_q.size()), 16'h0000, "completions still pending");
      complete_run();
   end
endmodule : test_return_rotate_subtract_exec
